// *** rtl/cimb_mask_bank.sv ***
`timescale 1ns/1ps

module cimb_mask_bank
	import cimb_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic srst_i,
	// Register port
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// Charge-status events
	input wire logic constant_voltage_phase_event_i,
	input wire logic charge_done_event_i,
	input wire logic input_current_limit_event_i,
	input wire logic system_power_path_mgmt_event_i,
	input wire logic input_voltage_power_mgmt_event_i,
	input wire logic thermal_regulation_event_i,
	input wire logic input_power_good_event_i,
	// Fault and temperature events
	input wire logic input_overvoltage_event_i,
	input wire logic battery_overcurrent_event_i,
	input wire logic battery_undervoltage_event_i,
	input wire logic thermistor_cold_region_event_i,
	input wire logic thermistor_cool_region_event_i,
	input wire logic thermistor_warm_region_event_i,
	input wire logic thermistor_hot_region_event_i,
	// ADC and thermistor events
	input wire logic adc_ready_event_i,
	input wire logic comparator_one_alarm_event_i,
	input wire logic comparator_two_alarm_event_i,
	input wire logic comparator_three_alarm_event_i,
	input wire logic thermistor_open_event_i,
	// Interrupt
	output logic irq_o
);

	cimb_state_t state_q;
	cimb_state_t state_d;
	logic [7:0] ev0;
	logic [7:0] ev1;
	logic [7:0] ev2;
	logic [7:0] pend0;
	logic [7:0] pend1;
	logic [7:0] pend2;
	logic rd0;
	logic rd1;
	logic rd2;

	// Event vectors in flag-register order; reserved positions tie low
	assign ev0 = {1'b0,
		constant_voltage_phase_event_i,
		charge_done_event_i,
		input_current_limit_event_i,
		system_power_path_mgmt_event_i,
		input_voltage_power_mgmt_event_i,
		thermal_regulation_event_i,
		input_power_good_event_i};
	assign ev1 = {input_overvoltage_event_i,
		1'b0,
		battery_overcurrent_event_i,
		battery_undervoltage_event_i,
		thermistor_cold_region_event_i,
		thermistor_cool_region_event_i,
		thermistor_warm_region_event_i,
		thermistor_hot_region_event_i};
	assign ev2 = {adc_ready_event_i,
		comparator_one_alarm_event_i,
		comparator_two_alarm_event_i,
		comparator_three_alarm_event_i,
		3'b000,
		thermistor_open_event_i};

	assign rd0 = reg_rd_i && (reg_addr_i == CIMB_FLAG0_ADDR);
	assign rd1 = reg_rd_i && (reg_addr_i == CIMB_FLAG1_ADDR);
	assign rd2 = reg_rd_i && (reg_addr_i == CIMB_FLAG2_ADDR);

	// A set flag only reaches the interrupt while its mask bit is zero
	assign pend0 = state_q.flag0 & ~state_q.charge_status_irq_mask & CIMB_FLAG0_IMPL;
	assign pend1 = state_q.flag1 & ~state_q.fault_temp_irq_mask & CIMB_FLAG1_IMPL;
	assign pend2 = state_q.flag2 & ~state_q.adc_thermistor_irq_mask & CIMB_FLAG2_IMPL;

	always_comb
	begin
		state_d = state_q;
		// Flags latch regardless of mask; set wins over clear-on-read
		state_d.flag0 = ((rd0 ? 8'h00 : state_q.flag0) | ev0) & CIMB_FLAG0_IMPL;
		state_d.flag1 = ((rd1 ? 8'h00 : state_q.flag1) | ev1) & CIMB_FLAG1_IMPL;
		state_d.flag2 = ((rd2 ? 8'h00 : state_q.flag2) | ev2) & CIMB_FLAG2_IMPL;
		// Reserved mask bits are plain storage, as the host may write them
		if (reg_wr_i)
		begin
			unique case (reg_addr_i)
				CIMB_CHARGE_STATUS_IRQ_MASK_ADDR: state_d.charge_status_irq_mask = reg_wdata_i;
				CIMB_FAULT_TEMP_IRQ_MASK_ADDR: state_d.fault_temp_irq_mask = reg_wdata_i;
				CIMB_ADC_THERMISTOR_IRQ_MASK_ADDR: state_d.adc_thermistor_irq_mask = reg_wdata_i;
				default: state_d.charge_status_irq_mask = state_q.charge_status_irq_mask;
			endcase
		end
		// Read data is the value before this cycle's clear
		state_d.rdata = CIMB_RDATA_RST;
		if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				CIMB_FLAG0_ADDR: state_d.rdata = state_q.flag0;
				CIMB_FLAG1_ADDR: state_d.rdata = state_q.flag1;
				CIMB_FLAG2_ADDR: state_d.rdata = state_q.flag2;
				CIMB_CHARGE_STATUS_IRQ_MASK_ADDR: state_d.rdata = state_q.charge_status_irq_mask;
				CIMB_FAULT_TEMP_IRQ_MASK_ADDR: state_d.rdata = state_q.fault_temp_irq_mask;
				CIMB_ADC_THERMISTOR_IRQ_MASK_ADDR: state_d.rdata = state_q.adc_thermistor_irq_mask;
				default: state_d.rdata = CIMB_RDATA_RST;
			endcase
		end
		else
		begin
			state_d.rdata = state_q.rdata;
		end
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (srst_i)
		begin
			state_q.charge_status_irq_mask <= CIMB_CHARGE_STATUS_IRQ_MASK_RST;
			state_q.fault_temp_irq_mask <= CIMB_FAULT_TEMP_IRQ_MASK_RST;
			state_q.adc_thermistor_irq_mask <= CIMB_ADC_THERMISTOR_IRQ_MASK_RST;
			state_q.flag0 <= CIMB_FLAG_RST;
			state_q.flag1 <= CIMB_FLAG_RST;
			state_q.flag2 <= CIMB_FLAG_RST;
			state_q.rdata <= CIMB_RDATA_RST;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	assign reg_rdata_o = state_q.rdata;
	// Level output; stays high until every unmasked flag is read away
	assign irq_o = |{pend0, pend1, pend2};

	// Mask writes in the same cycle change the gate one edge later
	logic wr_m0;
	logic wr_m1;
	logic wr_m2;
	assign wr_m0 = reg_wr_i && (reg_addr_i == CIMB_CHARGE_STATUS_IRQ_MASK_ADDR);
	assign wr_m1 = reg_wr_i && (reg_addr_i == CIMB_FAULT_TEMP_IRQ_MASK_ADDR);
	assign wr_m2 = reg_wr_i && (reg_addr_i == CIMB_ADC_THERMISTOR_IRQ_MASK_ADDR);

	property p_irq_cause;
		@(posedge sys_clk_i) disable iff (srst_i)
		irq_o |-> (|((state_q.flag0 & ~state_q.charge_status_irq_mask) | (state_q.flag1 & ~state_q.fault_temp_irq_mask)
			| (state_q.flag2 & ~state_q.adc_thermistor_irq_mask)));
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without unmasked flag");

	property p_all_masked;
		@(posedge sys_clk_i) disable iff (srst_i)
		(state_q.charge_status_irq_mask == 8'hFF && state_q.fault_temp_irq_mask == 8'hFF && state_q.adc_thermistor_irq_mask == 8'hFF) |-> !irq_o;
	endproperty
	a_all_masked: assert property (p_all_masked) else $error("irq while all masked");

	property p_cv;
		@(posedge sys_clk_i) disable iff (srst_i)
		(constant_voltage_phase_event_i && !state_q.charge_status_irq_mask[6] && !wr_m0) |=> irq_o;
	endproperty
	a_cv: assert property (p_cv) else $error("cv event lost");

	property p_done;
		@(posedge sys_clk_i) disable iff (srst_i)
		(charge_done_event_i && !state_q.charge_status_irq_mask[5] && !wr_m0) |=> irq_o;
	endproperty
	a_done: assert property (p_done) else $error("done event lost");

	property p_iinlim;
		@(posedge sys_clk_i) disable iff (srst_i)
		(input_current_limit_event_i && !state_q.charge_status_irq_mask[4] && !wr_m0) |=> irq_o;
	endproperty
	a_iinlim: assert property (p_iinlim) else $error("current limit event lost");

	property p_sysppm;
		@(posedge sys_clk_i) disable iff (srst_i)
		(system_power_path_mgmt_event_i && !state_q.charge_status_irq_mask[3] && !wr_m0) |=> irq_o;
	endproperty
	a_sysppm: assert property (p_sysppm) else $error("power path event lost");

	property p_vinpm;
		@(posedge sys_clk_i) disable iff (srst_i)
		(input_voltage_power_mgmt_event_i && !state_q.charge_status_irq_mask[2] && !wr_m0) |=> irq_o;
	endproperty
	a_vinpm: assert property (p_vinpm) else $error("input voltage event lost");

	property p_therm;
		@(posedge sys_clk_i) disable iff (srst_i)
		(thermal_regulation_event_i && !state_q.charge_status_irq_mask[1] && !wr_m0) |=> irq_o;
	endproperty
	a_therm: assert property (p_therm) else $error("thermal event lost");

	property p_pgood;
		@(posedge sys_clk_i) disable iff (srst_i)
		(input_power_good_event_i && !state_q.charge_status_irq_mask[0] && !wr_m0) |=> irq_o;
	endproperty
	a_pgood: assert property (p_pgood) else $error("power good event lost");

	property p_rst_low;
		@(posedge sys_clk_i)
		$past(srst_i) && !srst_i |-> (state_q.charge_status_irq_mask == 8'h00 && state_q.fault_temp_irq_mask == 8'h00);
	endproperty
	a_rst_low: assert property (p_rst_low) else $error("low masks not zero after reset");

	property p_ovp;
		@(posedge sys_clk_i) disable iff (srst_i)
		(input_overvoltage_event_i && !state_q.fault_temp_irq_mask[7] && !wr_m1) |=> irq_o;
	endproperty
	a_ovp: assert property (p_ovp) else $error("overvoltage event lost");

	property p_ocp;
		@(posedge sys_clk_i) disable iff (srst_i)
		(battery_overcurrent_event_i && !state_q.fault_temp_irq_mask[5] && !wr_m1) |=> irq_o;
	endproperty
	a_ocp: assert property (p_ocp) else $error("overcurrent event lost");

	property p_uvlo;
		@(posedge sys_clk_i) disable iff (srst_i)
		(battery_undervoltage_event_i && !state_q.fault_temp_irq_mask[4] && !wr_m1) |=> irq_o;
	endproperty
	a_uvlo: assert property (p_uvlo) else $error("undervoltage event lost");

	property p_cold;
		@(posedge sys_clk_i) disable iff (srst_i)
		(thermistor_cold_region_event_i && !state_q.fault_temp_irq_mask[CIMB_B1_COLD] && !wr_m1) |=> irq_o;
	endproperty
	a_cold: assert property (p_cold) else $error("cold event lost");

	property p_cool;
		@(posedge sys_clk_i) disable iff (srst_i)
		(thermistor_cool_region_event_i && !state_q.fault_temp_irq_mask[CIMB_B1_COOL] && !wr_m1) |=> irq_o;
	endproperty
	a_cool: assert property (p_cool) else $error("cool event lost");

	property p_warm;
		@(posedge sys_clk_i) disable iff (srst_i)
		(thermistor_warm_region_event_i && !state_q.fault_temp_irq_mask[CIMB_B1_WARM] && !wr_m1) |=> irq_o;
	endproperty
	a_warm: assert property (p_warm) else $error("warm event lost");

	property p_cold_masked;
		@(posedge sys_clk_i) disable iff (srst_i)
		(state_q.fault_temp_irq_mask == 8'h08 && state_q.flag1 == 8'h08 && state_q.flag0 == 8'h00
			&& state_q.flag2 == 8'h00) |-> !irq_o;
	endproperty
	a_cold_masked: assert property (p_cold_masked) else $error("cold passed its mask");

	property p_hot;
		@(posedge sys_clk_i) disable iff (srst_i)
		(thermistor_hot_region_event_i && !state_q.fault_temp_irq_mask[0] && !wr_m1) |=> irq_o;
	endproperty
	a_hot: assert property (p_hot) else $error("hot event lost");

	property p_adc;
		@(posedge sys_clk_i) disable iff (srst_i)
		(adc_ready_event_i && !state_q.adc_thermistor_irq_mask[7] && !wr_m2) |=> irq_o;
	endproperty
	a_adc: assert property (p_adc) else $error("adc event lost");

	property p_cmp1;
		@(posedge sys_clk_i) disable iff (srst_i)
		(comparator_one_alarm_event_i && !state_q.adc_thermistor_irq_mask[CIMB_B2_CMP1] && !wr_m2) |=> irq_o;
	endproperty
	a_cmp1: assert property (p_cmp1) else $error("comparator one event lost");

	property p_cmp2;
		@(posedge sys_clk_i) disable iff (srst_i)
		(comparator_two_alarm_event_i && !state_q.adc_thermistor_irq_mask[5] && !wr_m2) |=> irq_o;
	endproperty
	a_cmp2: assert property (p_cmp2) else $error("comparator two event lost");

	property p_cmp3;
		@(posedge sys_clk_i) disable iff (srst_i)
		(comparator_three_alarm_event_i && !state_q.adc_thermistor_irq_mask[CIMB_B2_CMP3] && !wr_m2) |=> irq_o;
	endproperty
	a_cmp3: assert property (p_cmp3) else $error("comparator three event lost");

	property p_open;
		@(posedge sys_clk_i) disable iff (srst_i)
		(thermistor_open_event_i && !state_q.adc_thermistor_irq_mask[0] && !wr_m2) |=> irq_o;
	endproperty
	a_open: assert property (p_open) else $error("thermistor open event lost");

	property p_rst_adc;
		@(posedge sys_clk_i)
		$past(srst_i) && !srst_i |-> state_q.adc_thermistor_irq_mask == 8'h71;
	endproperty
	a_rst_adc: assert property (p_rst_adc) else $error("adc mask reset value wrong");

	property p_clear_on_read;
		@(posedge sys_clk_i) disable iff (srst_i)
		(rd1 && ev1 == 8'h00) |=> (state_q.flag1 == 8'h00 && reg_rdata_o == $past(state_q.flag1));
	endproperty
	a_clear_on_read: assert property (p_clear_on_read) else $error("flag read did not clear");

	property p_set_wins;
		@(posedge sys_clk_i) disable iff (srst_i)
		(rd0 && charge_done_event_i) |=> state_q.flag0[CIMB_B0_DONE];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("event lost to read clear");

	property p_masked_latch;
		@(posedge sys_clk_i) disable iff (srst_i)
		(comparator_one_alarm_event_i && state_q.adc_thermistor_irq_mask[6]) |=> state_q.flag2[6];
	endproperty
	a_masked_latch: assert property (p_masked_latch) else $error("masked flag not latched");

	c_irq_rise: cover property (@(posedge sys_clk_i) disable iff (srst_i) $rose(irq_o));
	c_read_clear: cover property (@(posedge sys_clk_i) disable iff (srst_i)
		irq_o ##1 rd0 ##1 !irq_o);
	c_masked_event: cover property (@(posedge sys_clk_i) disable iff (srst_i)
		thermistor_open_event_i && state_q.adc_thermistor_irq_mask[0]);
	c_mask_write: cover property (@(posedge sys_clk_i) disable iff (srst_i)
		wr_m1 ##1 state_q.fault_temp_irq_mask != 8'h00);
	// Event and clear-on-read in one cycle; the event must survive
	c_set_wins: cover property (@(posedge sys_clk_i) disable iff (srst_i)
		rd0 && charge_done_event_i);

endmodule : cimb_mask_bank

// *** rtl/cimb_pkg.sv ***
package cimb_pkg;

	// Register offsets on the internal register port
	localparam logic [7:0] CIMB_FLAG0_ADDR = 8'h03;
	localparam logic [7:0] CIMB_FLAG1_ADDR = 8'h04;
	localparam logic [7:0] CIMB_FLAG2_ADDR = 8'h05;
	localparam logic [7:0] CIMB_CHARGE_STATUS_IRQ_MASK_ADDR = 8'h07;
	localparam logic [7:0] CIMB_FAULT_TEMP_IRQ_MASK_ADDR = 8'h08;
	localparam logic [7:0] CIMB_ADC_THERMISTOR_IRQ_MASK_ADDR = 8'h09;

	// Values after reset
	localparam logic [7:0] CIMB_CHARGE_STATUS_IRQ_MASK_RST = 8'h00;
	localparam logic [7:0] CIMB_FAULT_TEMP_IRQ_MASK_RST = 8'h00;
	localparam logic [7:0] CIMB_ADC_THERMISTOR_IRQ_MASK_RST = 8'h71;
	localparam logic [7:0] CIMB_FLAG_RST = 8'h00;
	localparam logic [7:0] CIMB_RDATA_RST = 8'h00;

	// Flag bits backed by an event source; the rest read as zero
	localparam logic [7:0] CIMB_FLAG0_IMPL = 8'h7F;
	localparam logic [7:0] CIMB_FLAG1_IMPL = 8'hBF;
	localparam logic [7:0] CIMB_FLAG2_IMPL = 8'hF1;

	// Field positions, charge-status bank
	localparam int CIMB_B0_CV = 6;
	localparam int CIMB_B0_DONE = 5;
	localparam int CIMB_B0_IINLIM = 4;
	localparam int CIMB_B0_SYSPPM = 3;
	localparam int CIMB_B0_VINPM = 2;
	localparam int CIMB_B0_THERM = 1;
	localparam int CIMB_B0_PGOOD = 0;

	// Field positions, fault/temperature bank
	localparam int CIMB_B1_OVP = 7;
	localparam int CIMB_B1_OCP = 5;
	localparam int CIMB_B1_UVLO = 4;
	localparam int CIMB_B1_COLD = 3;
	localparam int CIMB_B1_COOL = 2;
	localparam int CIMB_B1_WARM = 1;
	localparam int CIMB_B1_HOT = 0;

	// Field positions, ADC/thermistor bank
	localparam int CIMB_B2_ADC = 7;
	localparam int CIMB_B2_CMP1 = 6;
	localparam int CIMB_B2_CMP2 = 5;
	localparam int CIMB_B2_CMP3 = 4;
	localparam int CIMB_B2_OPEN = 0;

	typedef struct packed {
		logic [7:0] charge_status_irq_mask;
		logic [7:0] fault_temp_irq_mask;
		logic [7:0] adc_thermistor_irq_mask;
		logic [7:0] flag0;
		logic [7:0] flag1;
		logic [7:0] flag2;
		logic [7:0] rdata;
	} cimb_state_t;

endpackage : cimb_pkg

// *** tb/cimb_host_model.sv ***
`timescale 1ns/1ps

module cimb_host_model
(
	// Clock
	input wire logic sys_clk_i,
	// Register port
	output logic [7:0] reg_addr_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	output logic [7:0] reg_wdata_o,
	input wire logic [7:0] reg_rdata_i
);

	initial
	begin
		reg_addr_o = 8'h00;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_wdata_o = 8'h00;
	end

	// Released lines show the inverse, so a stale value never reads as valid
	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		@(posedge sys_clk_i);
		reg_addr_o <= addr;
		reg_wdata_o <= data;
		reg_wr_o <= 1'b1;
		@(posedge sys_clk_i);
		reg_wr_o <= 1'b0;
		reg_addr_o <= ~addr;
		reg_wdata_o <= ~data;
	endtask : wr

	// Read data is registered, so it is taken just after the sampling edge
	task automatic rd(input logic [7:0] addr, output logic [7:0] data);
		@(posedge sys_clk_i);
		reg_addr_o <= addr;
		reg_rd_o <= 1'b1;
		@(posedge sys_clk_i);
		reg_rd_o <= 1'b0;
		reg_addr_o <= ~addr;
		#1;
		data = reg_rdata_i;
	endtask : rd

endmodule : cimb_host_model

// *** tb/tb.sv ***
`timescale 1ns/1ps

module tb;
	import cimb_pkg::*;

	logic sys_clk_i;
	logic srst_i;
	logic [7:0] reg_addr;
	logic reg_wr;
	logic reg_rd;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic irq;
	logic [18:0] ev;
	int err_count;
	int tests_run;
	// Source order: charge-status bank, fault/temperature bank, ADC/thermistor bank
	int ev_bank[19] = '{0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2};
	int ev_bit[19] = '{6, 5, 4, 3, 2, 1, 0, 7, 5, 4, 3, 2, 1, 0, 7, 6, 5, 4, 0};

	cimb_mask_bank DUT (
		.sys_clk_i(sys_clk_i),
		.srst_i(srst_i),
		.reg_addr_i(reg_addr),
		.reg_wr_i(reg_wr),
		.reg_rd_i(reg_rd),
		.reg_wdata_i(reg_wdata),
		.reg_rdata_o(reg_rdata),
		.constant_voltage_phase_event_i(ev[0]),
		.charge_done_event_i(ev[1]),
		.input_current_limit_event_i(ev[2]),
		.system_power_path_mgmt_event_i(ev[3]),
		.input_voltage_power_mgmt_event_i(ev[4]),
		.thermal_regulation_event_i(ev[5]),
		.input_power_good_event_i(ev[6]),
		.input_overvoltage_event_i(ev[7]),
		.battery_overcurrent_event_i(ev[8]),
		.battery_undervoltage_event_i(ev[9]),
		.thermistor_cold_region_event_i(ev[10]),
		.thermistor_cool_region_event_i(ev[11]),
		.thermistor_warm_region_event_i(ev[12]),
		.thermistor_hot_region_event_i(ev[13]),
		.adc_ready_event_i(ev[14]),
		.comparator_one_alarm_event_i(ev[15]),
		.comparator_two_alarm_event_i(ev[16]),
		.comparator_three_alarm_event_i(ev[17]),
		.thermistor_open_event_i(ev[18]),
		.irq_o(irq)
	);

	cimb_host_model host (
		.sys_clk_i(sys_clk_i),
		.reg_addr_o(reg_addr),
		.reg_wr_o(reg_wr),
		.reg_rd_o(reg_rd),
		.reg_wdata_o(reg_wdata),
		.reg_rdata_i(reg_rdata)
	);

	initial
	begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		tests_run++;
		if (got !== exp)
		begin
			$display("BAD %s expected %h seen %h", what, exp, got);
			err_count++;
		end
	endtask : chk

	task automatic complete_run();
		if (err_count == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : complete_run

	task automatic do_reset();
		@(posedge sys_clk_i);
		srst_i <= 1'b1;
		repeat (5) @(posedge sys_clk_i);
		srst_i <= 1'b0;
	endtask : do_reset

	task automatic pulse(input int i);
		@(posedge sys_clk_i);
		ev[i] <= 1'b1;
		@(posedge sys_clk_i);
		ev[i] <= 1'b0;
		#1;
	endtask : pulse

	task automatic t_reset();
		logic [7:0] d;
		#1;
		chk("irq after reset", 8'h00, {7'h00, irq});
		host.rd(8'h07, d);
		chk("charge_status_irq_mask reset", 8'h00, d);
		host.rd(8'h08, d);
		chk("fault_temp_irq_mask reset", 8'h00, d);
		host.rd(8'h09, d);
		chk("adc_thermistor_irq_mask reset", 8'h71, d);
	endtask : t_reset

	task automatic t_rw();
		logic [7:0] d;
		host.wr(8'h07, 8'hA5);
		host.wr(8'h08, 8'h5A);
		host.wr(8'h09, 8'hFF);
		host.wr(8'h03, 8'hFF);
		host.rd(8'h07, d);
		chk("charge_status_irq_mask rw", 8'hA5, d);
		host.rd(8'h08, d);
		chk("fault_temp_irq_mask rw", 8'h5A, d);
		host.rd(8'h09, d);
		chk("adc_thermistor_irq_mask rw", 8'hFF, d);
		host.rd(8'h03, d);
		chk("flag write ignored", 8'h00, d);
		host.rd(8'h0B, d);
		chk("unmapped read", 8'h00, d);
		chk("irq idle", 8'h00, {7'h00, irq});
	endtask : t_rw

	// Every source once unmasked and once masked; masked flags must still latch
	task automatic t_sources();
		logic [7:0] ma;
		logic [7:0] fa;
		logic [7:0] bv;
		logic [7:0] d;
		for (int i = 0; i < 19; i++)
		begin
			ma = 8'(CIMB_CHARGE_STATUS_IRQ_MASK_ADDR + ev_bank[i]);
			fa = 8'(CIMB_FLAG0_ADDR + ev_bank[i]);
			bv = 8'h01 << ev_bit[i];
			host.wr(ma, 8'h00);
			pulse(i);
			chk("irq unmasked", 8'h01, {7'h00, irq});
			host.rd(fa, d);
			chk("flag", bv, d);
			chk("irq after flag read", 8'h00, {7'h00, irq});
			host.rd(fa, d);
			chk("flag cleared", 8'h00, d);
			host.wr(ma, bv);
			pulse(i);
			chk("irq masked", 8'h00, {7'h00, irq});
			host.rd(fa, d);
			chk("masked flag", bv, d);
		end
	endtask : t_sources

	// Read of the charge-status flags in the very cycle its event fires
	task automatic t_set_wins();
		logic [7:0] d;
		fork
			host.rd(CIMB_FLAG0_ADDR, d);
			pulse(1);
		join
		chk("read during event", 8'h00, d);
		chk("irq after read during event", 8'h01, {7'h00, irq});
		host.rd(CIMB_FLAG0_ADDR, d);
		chk("flag set in read cycle", 8'h20, d);
		repeat (2) @(posedge sys_clk_i);
		#1;
		chk("read data holds", 8'h20, reg_rdata);
	endtask : t_set_wins

	initial
	begin
		srst_i = 1'b1;
		ev = 19'h00000;
		err_count = 0;
		tests_run = 0;
		do_reset();
		t_reset();
		t_rw();
		do_reset();
		t_reset();
		t_sources();
		t_set_wins();
		complete_run();
	end

	// Full run needs well under 2000 cycles
	initial
	begin
		repeat (20000) @(posedge sys_clk_i);
		err_count++;
		complete_run();
	end

endmodule : tb
